// ===== sixteen_bit_match_timer.v
// 16-bit match timer: interval, event count, square wave, PWM
// Assumes an APB master on pclk and an asynchronous event pin
`timescale 1ns/100ps
`include "timer_consts.vh"
module sixteen_bit_match_timer
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        event_input_pin,
  output reg         wave_output_pin,
  output reg         match_interrupt
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg        count_run_bit_q;
  reg        pwm_mode_select_q;
  reg        invert_or_polarity_bit_q;
  reg        wave_output_enable_q;
  reg [15:0] compare_value_q;
  reg [15:0] count_value_q;
  reg [2:0]  clock_select_first_q;
  reg        clock_select_second_q;
  reg        out_ff_q;
  reg        pwm_active_q;

  wire       ev_rise;
  wire       ev_fall;
  wire       tick;

  // ----------------------------------------
  // Reset image of the mode register
  // ----------------------------------------
  // Hardware holds 04H; bits 3 and 2 never read back, so software sees 00H
  localparam [7:0] MODE_RST = `RST_MODE;
  localparam [0:0] RUN_RST  = MODE_RST[`BIT_RUN];
  localparam [0:0] PWM_RST  = MODE_RST[`BIT_PWM];
  localparam [0:0] INV_RST  = MODE_RST[`BIT_INV_POL];
  localparam [0:0] OE_RST   = MODE_RST[`BIT_OUT_EN];
  localparam [0:0] FF_RST   = MODE_RST[`BIT_FF_SET] & ~MODE_RST[`BIT_FF_CLR];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Two-cycle access: pready comes one edge after penable
  wire acc_first = psel & penable & ~pready;
  wire acc_done  = psel & penable & pready;
  wire do_wr     = acc_done & pwrite;

  wire hit_mode  = (paddr == `OFF_MODE);
  wire hit_cmp   = (paddr == `OFF_COMPARE);
  wire hit_cnt   = (paddr == `OFF_COUNT);
  wire hit_sel1  = (paddr == `OFF_SEL_FIRST);
  wire hit_sel2  = (paddr == `OFF_SEL_SECND);
  wire hit_stat  = (paddr == `OFF_STATUS);
  wire hit_set   = (paddr == `OFF_MODE_SET);
  wire hit_clr   = (paddr == `OFF_MODE_CLR);
  wire mapped    = hit_mode | hit_cmp | hit_cnt | hit_sel1 |
                   hit_sel2 | hit_stat | hit_set | hit_clr;

  wire wr_mode   = do_wr & hit_mode;
  wire wr_set    = do_wr & hit_set;
  wire wr_clr    = do_wr & hit_clr;

  // ----------------------------------------
  // Mode control next value
  // ----------------------------------------
  reg [7:0] mode_now;
  reg [7:0] mode_d;
  reg [1:0] ff_cmd;

  always @*
  begin
    mode_now = 8'h00;
    mode_now[`BIT_RUN]     = count_run_bit_q;
    mode_now[`BIT_PWM]     = pwm_mode_select_q;
    mode_now[`BIT_INV_POL] = invert_or_polarity_bit_q;
    mode_now[`BIT_OUT_EN]  = wave_output_enable_q;
    mode_d = mode_now;
    ff_cmd = 2'b00;
    if (wr_mode)
    begin
      mode_d = pwdata[7:0];
      ff_cmd = pwdata[`BIT_FF_SET:`BIT_FF_CLR];
    end
    else if (wr_set)
    begin
      mode_d = mode_now | pwdata[7:0];
      ff_cmd = pwdata[`BIT_FF_SET:`BIT_FF_CLR];
    end
    else if (wr_clr)
    begin
      mode_d = mode_now & ~pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_run_bit_q          <= RUN_RST;
      pwm_mode_select_q        <= PWM_RST;
      invert_or_polarity_bit_q <= INV_RST;
      wave_output_enable_q     <= OE_RST;
      compare_value_q          <= `RST_COMPARE;
      clock_select_first_q     <= `RST_SEL;
      clock_select_second_q    <= 1'b0;
    end
    else if (ce)
    begin
      count_run_bit_q          <= mode_d[`BIT_RUN];
      pwm_mode_select_q        <= mode_d[`BIT_PWM];
      invert_or_polarity_bit_q <= mode_d[`BIT_INV_POL];
      wave_output_enable_q     <= mode_d[`BIT_OUT_EN];
      if (do_wr & hit_cmp)
        compare_value_q <= pwdata[15:0];
      if (do_wr & hit_sel1)
        clock_select_first_q <= pwdata[2:0];
      if (do_wr & hit_sel2)
        clock_select_second_q <= pwdata[0];
    end
  end

  // ----------------------------------------
  // Count clock
  // ----------------------------------------
  event_edge_detect u_edge
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pin     (event_input_pin),
    .rise    (ev_rise),
    .fall    (ev_fall)
  );

  count_prescaler u_presc
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .run     (count_run_bit_q),
    .code    ({clock_select_second_q, clock_select_first_q}),
    .ev_rise (ev_rise),
    .ev_fall (ev_fall),
    .tick    (tick)
  );

  // ----------------------------------------
  // Counter and match
  // ----------------------------------------
  wire at_compare = (count_value_q == compare_value_q);
  wire at_max     = (count_value_q == 16'hffff);
  // Divided clock restarts with run, but an event edge lands anywhere: first match may lag
  wire match_hit  = count_run_bit_q & tick & at_compare;
  wire overflow   = count_run_bit_q & tick & pwm_mode_select_q & at_max;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_value_q <= 16'h0000;
    else if (ce)
    begin
      if (!count_run_bit_q)
        count_value_q <= 16'h0000;
      else if (tick)
      begin
        if (!pwm_mode_select_q && at_compare)
          count_value_q <= 16'h0000;
        else
          count_value_q <= count_value_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Output flip-flop
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_ff_q <= FF_RST;
    else if (ce)
    begin
      // Software command beats a toggle landing in the same cycle
      case (ff_cmd)
        2'b01:   out_ff_q <= 1'b0;
        2'b10:   out_ff_q <= 1'b1;
        2'b00:
        begin
          if (match_hit && !pwm_mode_select_q &&
              invert_or_polarity_bit_q)
            out_ff_q <= ~out_ff_q;
        end
        default: out_ff_q <= out_ff_q;
      endcase
    end
  end

  // ----------------------------------------
  // PWM level
  // ----------------------------------------
  // Compare at ffff leaves the level active all period
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_active_q <= 1'b0;
    else if (ce)
    begin
      if (!count_run_bit_q || !pwm_mode_select_q)
        pwm_active_q <= 1'b0;
      else if (overflow)
        pwm_active_q <= 1'b1;
      else if (match_hit)
        pwm_active_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin and interrupt
  // ----------------------------------------
  reg pin_d;

  always @*
  begin
    pin_d = 1'b0;
    if (wave_output_enable_q)
    begin
      if (pwm_mode_select_q)
        pin_d = pwm_active_q ^ invert_or_polarity_bit_q;
      else
        pin_d = out_ff_q;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wave_output_pin <= 1'b0;
      match_interrupt <= 1'b0;
    end
    else if (ce)
    begin
      wave_output_pin <= pin_d;
      match_interrupt <= match_hit;
    end
    else
      match_interrupt <= 1'b0;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  reg [31:0] rd_d;

  always @*
  begin
    rd_d = 32'h0000_0000;
    if (hit_mode)
      rd_d[7:0] = mode_now;
    else if (hit_cmp)
      rd_d[15:0] = compare_value_q;
    else if (hit_cnt)
      rd_d[15:0] = count_value_q;
    else if (hit_sel1)
      rd_d[2:0] = clock_select_first_q;
    else if (hit_sel2)
      rd_d[0] = clock_select_second_q;
    else if (hit_stat)
      rd_d[1:0] = {pwm_active_q, out_ff_q};
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready  <= acc_first;
      pslverr <= acc_first & ~mapped;
      if (acc_first && !pwrite)
        prdata <= rd_d;
    end
  end

endmodule // sixteen_bit_match_timer

// ===== timer_consts.vh
// Constants of the 16-bit match timer: offsets, fields, resets
// Assumes one APB slot of 8 address bits, one word per register
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_MODE      8'h00
`define OFF_COMPARE   8'h04
`define OFF_COUNT     8'h08
`define OFF_SEL_FIRST 8'h0c
`define OFF_SEL_SECND 8'h10
`define OFF_STATUS    8'h14
`define OFF_MODE_SET  8'h18
`define OFF_MODE_CLR  8'h1c

// ----------------------------------------
// Mode control fields
// ----------------------------------------
`define BIT_RUN       7
`define BIT_PWM       6
`define BIT_FF_SET    3
`define BIT_FF_CLR    2
`define BIT_INV_POL   1
`define BIT_OUT_EN    0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_MODE      8'h04
`define RST_COMPARE   16'h0000
`define RST_SEL       3'h0

// ----------------------------------------
// Count clock codes {second[0], first[2:0]}
// ----------------------------------------
`define CODE_EV_FALL  4'h0
`define CODE_EV_RISE  4'h1
`define CODE_DIV4     4'h2
`define CODE_DIV8     4'h3
`define CODE_DIV16    4'h4
`define CODE_DIV32    4'h5
`define CODE_DIV64    4'h6
`define CODE_DIV128   4'h7
`define CODE_DIV256   4'ha
`define CODE_DIV512   4'hb
`define PRESC_W       9

`endif

// ===== event_edge_detect.v
// Event input pin synchroniser and edge detector
// Assumes the pin is asynchronous to pclk
`timescale 1ns/100ps
module event_edge_detect
(
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  input  wire pin,
  output wire rise,
  output wire fall
);
  reg sync1_q;
  reg sync2_q;
  reg last_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q  <= 1'b0;
    end
    else if (ce)
    begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
    end
  end

  assign rise = ce & sync2_q & ~last_q;
  assign fall = ce & ~sync2_q & last_q;
endmodule // event_edge_detect

// ===== count_prescaler.v
// Prescaler producing the count pulse from pclk or the event pin
// Assumes edge pulses are already synchronous to pclk
`timescale 1ns/100ps
`include "timer_consts.vh"
module count_prescaler
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire       ce,
  input  wire       run,
  input  wire [3:0] code,
  input  wire       ev_rise,
  input  wire       ev_fall,
  output wire       tick
);
  reg [`PRESC_W-1:0] presc_q;

  // Prohibited codes give an all-zero mask and no pulse
  function [`PRESC_W:0] div_mask;
    input [3:0] c;
    begin
      case (c)
        `CODE_DIV4:   div_mask = 10'h203;
        `CODE_DIV8:   div_mask = 10'h207;
        `CODE_DIV16:  div_mask = 10'h20f;
        `CODE_DIV32:  div_mask = 10'h21f;
        `CODE_DIV64:  div_mask = 10'h23f;
        `CODE_DIV128: div_mask = 10'h27f;
        `CODE_DIV256: div_mask = 10'h2ff;
        `CODE_DIV512: div_mask = 10'h3ff;
        default:      div_mask = 10'h000;
      endcase
    end
  endfunction

  wire [`PRESC_W:0] mask = div_mask(code);

  // Prescaler held at zero while halted
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc_q <= {`PRESC_W{1'b0}};
    else if (ce)
    begin
      if (!run)
        presc_q <= {`PRESC_W{1'b0}};
      else
        presc_q <= presc_q + 1'b1;
    end
  end

  assign tick = run & ce & ((code == `CODE_EV_FALL) ? ev_fall :
                (code == `CODE_EV_RISE) ? ev_rise :
                (mask[`PRESC_W] &
                 ((presc_q & mask[`PRESC_W-1:0]) == mask[`PRESC_W-1:0])));
endmodule // count_prescaler

// ===== timer_checker.sv
// Port checker of the 16-bit match timer
// Assumes one pclk domain and the offsets of timer_consts.vh
`timescale 1ns/100ps
`include "timer_consts.vh"
module timer_checker
(
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        event_input_pin,
  input wire        wave_output_pin,
  input wire        match_interrupt
);
  reg [7:0] mode_q;
  // ----------------------------------------
  // Mode shadow, from completed APB writes
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= `RST_MODE;
    else if (pready && pwrite && paddr == `OFF_MODE)
      mode_q <= pwdata[7:0];
    else if (pready && pwrite && paddr == `OFF_MODE_SET)
      mode_q <= mode_q | pwdata[7:0];
    else if (pready && pwrite && paddr == `OFF_MODE_CLR)
      mode_q <= mode_q & ~pwdata[7:0];
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_rdy;
    pready |=> !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready longer than one cycle");
  property p_answer;
    psel && penable && !pready |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("access not answered");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_ffrd;
    pready && !pwrite && paddr == `OFF_MODE |-> prdata[3:2] == 2'b00;
  endproperty
  a_ffrd: assert property (p_ffrd) else $error("set/clear bits read nonzero");
  property p_stop;
    pready && !pwrite && paddr == `OFF_COUNT && !mode_q[7] |-> prdata[15:0] == 16'h0000;
  endproperty
  a_stop: assert property (p_stop) else $error("count nonzero while stopped");
  property p_irq;
    match_interrupt |=> !match_interrupt;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt longer than one cycle");
  property p_tog;
    $changed(wave_output_pin) && !mode_q[6] && !$past(pready) && !$past(pready, 2) |-> $past(match_interrupt);
  endproperty
  a_tog: assert property (p_tog) else $error("output changed without match");
  property p_idle;
    (!mode_q[7] && mode_q[6] && mode_q[0] && $stable(mode_q)) [*2] |=> wave_output_pin == mode_q[1];
  endproperty
  a_idle: assert property (p_idle) else $error("stopped pwm output not inactive");
endmodule // timer_checker

bind sixteen_bit_match_timer timer_checker i_timer_checker
(
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .event_input_pin(event_input_pin), .wave_output_pin(wave_output_pin), .match_interrupt(match_interrupt)
);

// ===== event_source.sv
// Far-side model: event pulse source on the timer input pin
// Assumes callers sit just after a rising pclk edge
`timescale 1ns/100ps
module event_source
(
  input  wire  pclk,
  output logic event_input_pin
);
  initial
    event_input_pin = 1'b0;
  // Short holds stress the two-flop synchroniser
  task automatic drive_edge(input logic lvl, input integer hold);
    event_input_pin <= lvl;
    repeat (hold) @(posedge pclk);
  endtask
endmodule // event_source

// ===== testbench.sv
// Self-checking bench of the 16-bit match timer
// Assumes the bound checker and the event source model
`timescale 1ns/100ps
`include "timer_consts.vh"
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        ce = 1'b1;
  logic [31:0] rd;
  logic        err;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         ev_pin;
  wire         wave;
  wire         irq;
  integer      fail_count = 0;
  integer      tests_run = 0;
  integer      cyc = 0;
  integer      irqs = 0;
  always #10 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (irq === 1'b1)
      irqs = irqs + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      print_verdict;
    end
  end
  sixteen_bit_match_timer i_sixteen_bit_match_timer
  (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_input_pin(ev_pin), .wave_output_pin(wave), .match_interrupt(irq)
  );
  event_source i_event_source(.pclk(pclk), .event_input_pin(ev_pin));
  // ----------------------------------------
  // Shared tasks, all entered just after an edge
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic wait_irq(output integer k);
    k = 0;
    do
    begin
      @(posedge pclk);
      k = k + 1;
    end
    while (irq !== 1'b1);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [47:0] cmd;
    logic [5:0]  ff;
    cmd = 48'h08_00_04_00_08_0c;
    ff = 6'b110011;
    chk("mode at reset", `OFF_MODE, 32'h0);
    chk("unmapped", 8'h20, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, `OFF_MODE, {24'h0, cmd[8*(5-i) +: 8]});
      chk("out ff", `OFF_STATUS, {31'h0, ff[5-i]});
      chk("ff bits", `OFF_MODE, 32'h0);
    end
    apb(1'b1, `OFF_MODE_SET, 32'h3);
    chk("bit set", `OFF_MODE, 32'h3);
    apb(1'b1, `OFF_MODE_CLR, 32'h1);
    chk("bit clear", `OFF_MODE, 32'h2);
  endtask
  task automatic t_interval;
    integer k;
    logic   lvl;
    apb(1'b1, `OFF_MODE, 32'h2);
    apb(1'b1, `OFF_COMPARE, 32'h2);
    apb(1'b1, `OFF_SEL_FIRST, 32'h2);
    apb(1'b1, `OFF_SEL_SECND, 32'h0);
    apb(1'b1, `OFF_MODE_SET, 32'h80);
    wait_irq(k);
    check("first match", {31'h0, k <= 16}, 32'h1);
    apb(1'b1, `OFF_MODE_SET, 32'h1);
    wait_irq(k);
    lvl = wave;
    wait_irq(k);
    check("interval", k, 32'hc);
    check("toggle", {30'h0, lvl, wave}, 32'h1);
    ce <= 1'b0;
    repeat (8) @(posedge pclk);
    ce <= 1'b1;
    wait_irq(k);
    check("frozen interval", k, 32'hc);
    apb(1'b1, `OFF_MODE_CLR, 32'h80);
    chk("count stopped", `OFF_COUNT, 32'h0);
  endtask
  task automatic t_clocks;
    integer      k;
    integer      n;
    logic [31:0] codes;
    codes = 32'hba76_5432;
    apb(1'b1, `OFF_COMPARE, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, `OFF_SEL_FIRST, {29'h0, codes[4*i +: 3]});
      apb(1'b1, `OFF_SEL_SECND, {31'h0, codes[4*i+3]});
      apb(1'b1, `OFF_MODE_SET, 32'h80);
      wait_irq(k);
      wait_irq(k);
      check("divided period", k, 32'h4 << i);
      apb(1'b1, `OFF_MODE_CLR, 32'h80);
    end
    apb(1'b1, `OFF_SEL_FIRST, 32'h0);
    apb(1'b1, `OFF_MODE_SET, 32'h80);
    n = irqs;
    repeat (40) @(posedge pclk);
    check("prohibited code", irqs - n, 32'h0);
    apb(1'b1, `OFF_MODE_CLR, 32'h80);
    apb(1'b1, `OFF_SEL_SECND, 32'h0);
  endtask
  task automatic t_event;
    integer n;
    apb(1'b1, `OFF_COMPARE, 32'h1);
    for (int e = 0; e < 2; e++)
    begin
      apb(1'b1, `OFF_SEL_FIRST, e);
      apb(1'b1, `OFF_MODE_SET, 32'h80);
      i_event_source.drive_edge(1'b1, 6);
      chk("after rise", `OFF_COUNT, e);
      i_event_source.drive_edge(1'b0, 6);
      chk("after fall", `OFF_COUNT, 32'h1);
      apb(1'b1, `OFF_MODE_CLR, 32'h80);
    end
    apb(1'b1, `OFF_MODE_SET, 32'h80);
    i_event_source.drive_edge(1'b1, 3);
    i_event_source.drive_edge(1'b0, 3);
    n = irqs;
    i_event_source.drive_edge(1'b1, 3);
    i_event_source.drive_edge(1'b0, 9);
    check("event irq", irqs - n, 32'h1);
    chk("event clear", `OFF_COUNT, 32'h0);
    apb(1'b1, `OFF_MODE_CLR, 32'h80);
  endtask
  task automatic t_pwm;
    apb(1'b1, `OFF_SEL_FIRST, 32'h2);
    apb(1'b1, `OFF_MODE, 32'h43);
    repeat (2) @(posedge pclk);
    check("idle active-low", {31'h0, wave}, 32'h1);
    apb(1'b1, `OFF_MODE_SET, 32'h80);
    repeat (40) @(posedge pclk);
    apb(1'b0, `OFF_COUNT, 32'h0);
    check("no clear on match", {31'h0, rd > 32'h1}, 32'h1);
    check("before overflow", {31'h0, wave}, 32'h1);
    apb(1'b1, `OFF_MODE_CLR, 32'h82);
    repeat (4) @(posedge pclk);
    check("stopped active-high", {31'h0, wave}, 32'h0);
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_interval;
    t_clocks;
    t_event;
    t_pwm;
    print_verdict;
  end
endmodule // testbench
